// File: hdl/oag_pkg.sv
// oag_pkg: shared constants and types of the operand address generator
// assumes a 16-bit word machine with eight general registers
package oag_pkg;

    // ------------------------------------------------------------------
    // widths and register file shape
    // ------------------------------------------------------------------
    localparam int OAG_ADDR_W = 16;
    localparam int OAG_GPR_COUNT = 8;
    localparam logic [15:0] OAG_GPR_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // addressing modes (3-bit mode field)
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_REGISTER = 3'h0;
    localparam logic [2:0] MODE_DEFERRED = 3'h1;
    localparam logic [2:0] MODE_POST_INC = 3'h2;
    localparam logic [2:0] MODE_POST_INC_DEF = 3'h3;
    localparam logic [2:0] MODE_PRE_DEC = 3'h4;
    localparam logic [2:0] MODE_PRE_DEC_DEF = 3'h5;
    localparam logic [2:0] MODE_INDEX = 3'h6;
    localparam logic [2:0] MODE_INDEX_DEF = 3'h7;

    // ------------------------------------------------------------------
    // special registers and step sizes
    // ------------------------------------------------------------------
    localparam logic [2:0] stack_pointer_reg = 3'h6;
    localparam logic [2:0] program_counter_reg = 3'h7;
    localparam logic [15:0] OAG_STEP_WORD = 16'h0002;
    localparam logic [15:0] OAG_STEP_BYTE = 16'h0001;

    typedef logic [OAG_ADDR_W-1:0] oag_word_t;

    typedef enum logic [4:0] {
        OAG_IDLE = 5'h01,
        OAG_EVAL = 5'h02,
        OAG_IMM = 5'h04,
        OAG_IDX = 5'h08,
        OAG_PTR = 5'h10
    } oag_state_t;

endpackage

// File: hdl/oag_regfile_if.sv
// oag_regfile_if: register file read and update port used by the generator
// assumes one clock domain; the generator drives, the register file answers
`timescale 1ns/1ps
interface oag_regfile_if;
    import oag_pkg::*;
    logic [2:0] rd_sel;
    oag_word_t rd_data;
    oag_word_t pc_value;
    logic wr_en;
    logic [2:0] wr_sel;
    oag_word_t wr_data;

    modport gen (output rd_sel, output wr_en, output wr_sel, output wr_data, input rd_data, input pc_value);
    modport rf (input rd_sel, input wr_en, input wr_sel, input wr_data, output rd_data, output pc_value);
endinterface

// File: hdl/oag_stepper.sv
// oag_stepper: adds or subtracts the operand step from a register value
// assumes purely combinational use inside the generator
`timescale 1ns/1ps
module oag_stepper
    import oag_pkg::*;
(
    // operands
    input wire oag_word_t base,
    input wire logic byte_op,
    input wire logic word_only,
    input wire logic decrement,
    // result
    output oag_word_t result
);

    oag_word_t step;

    // pointers and stack/program counter always move by a full word
    always_comb begin
        step = (byte_op && !word_only) ? OAG_STEP_BYTE : OAG_STEP_WORD;
        result = decrement ? oag_word_t'(base - step) : oag_word_t'(base + step); // wraps in 16 bits
    end

endmodule

// File: hdl/oag_regfile.sv
// oag_regfile: eight general registers held in flip-flops
// assumes the generator update and the external load share one clock
`timescale 1ns/1ps
module oag_regfile
    import oag_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // generator side
    oag_regfile_if.rf port,
    // external load from the rest of the processor
    input wire logic load_en,
    input wire logic [2:0] load_sel,
    input wire oag_word_t load_data
);

    oag_word_t gpr [OAG_GPR_COUNT];
    oag_word_t next_gpr [OAG_GPR_COUNT];

    // reads are combinational so the generator sees values in the same cycle
    assign port.rd_data = gpr[port.rd_sel];
    assign port.pc_value = gpr[program_counter_reg];

    // generator update wins over an external load to keep address math coherent
    always_comb begin
        next_gpr = gpr;
        if (port.wr_en) begin
            next_gpr[port.wr_sel] = port.wr_data;
        end else if (load_en) begin
            next_gpr[load_sel] = load_data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < OAG_GPR_COUNT; i++) begin
                gpr[i] <= OAG_GPR_RESET;
            end
        end else begin
            gpr <= next_gpr;
        end
    end

endmodule

// File: hdl/oag_operand_address_generator.sv
// oag_operand_address_generator: operand effective-address generation
// assumes the memory path answers each held mem_req with a one-cycle mem_ack
`timescale 1ns/1ps

module oag_operand_address_generator
    import oag_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // operand specifier request
    input wire logic start,
    input wire logic [2:0] mode,
    input wire logic [2:0] reg_sel,
    input wire logic byte_op,
    output logic busy,
    // result
    output logic done,
    output logic operand_in_reg,
    output logic operand_is_imm,
    output oag_word_t operand_value,
    output logic eff_addr_valid,
    output oag_word_t eff_addr,
    // memory read path
    output logic mem_req,
    output oag_word_t mem_addr,
    output logic mem_istream,
    input wire logic mem_ack,
    input wire oag_word_t mem_rdata,
    // register load from the processor
    input wire logic load_en,
    input wire logic [2:0] load_sel,
    input wire oag_word_t load_data
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    oag_state_t state, next_state;
    logic [2:0] cur_mode, next_cur_mode;
    logic [2:0] cur_sel, next_cur_sel;
    logic cur_byte, next_cur_byte;
    logic next_busy, next_done, next_in_reg, next_is_imm, next_ea_valid;
    oag_word_t next_operand_value, next_eff_addr, next_mem_addr;
    logic next_mem_req, next_mem_istream;
    oag_word_t reg_stepped, pc_stepped, index_base, index_sum;
    logic force_word, is_dec, sel_is_pc;

    oag_regfile_if rfp();

    // ------------------------------------------------------------------
    // register file and step units
    // ------------------------------------------------------------------
    oag_regfile u_regfile (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .port(rfp.rf),
        .load_en(load_en),
        .load_sel(load_sel),
        .load_data(load_data)
    );

    // deferred modes move by a pointer width regardless of operand size
    assign sel_is_pc = (cur_sel == program_counter_reg);
    assign force_word = (cur_sel == stack_pointer_reg) || sel_is_pc
        || (cur_mode == MODE_POST_INC_DEF) || (cur_mode == MODE_PRE_DEC_DEF);
    assign is_dec = (cur_mode == MODE_PRE_DEC) || (cur_mode == MODE_PRE_DEC_DEF);

    oag_stepper u_reg_step (
        .base(rfp.rd_data),
        .byte_op(cur_byte),
        .word_only(force_word),
        .decrement(is_dec),
        .result(reg_stepped)
    );

    // program counter always advances by one word per stream fetch
    oag_stepper u_pc_step (
        .base(rfp.pc_value),
        .byte_op(1'b0),
        .word_only(1'b1),
        .decrement(1'b0),
        .result(pc_stepped)
    );

    // with the counter as base the updated value (index word address + 2) is used
    assign index_base = sel_is_pc ? pc_stepped : rfp.rd_data;
    assign index_sum = oag_word_t'(mem_rdata + index_base);
    assign rfp.rd_sel = cur_sel;

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cur_mode = cur_mode;
        next_cur_sel = cur_sel;
        next_cur_byte = cur_byte;
        next_busy = busy;
        next_done = 1'b0;
        next_in_reg = operand_in_reg;
        next_is_imm = operand_is_imm;
        next_ea_valid = eff_addr_valid;
        next_operand_value = operand_value;
        next_eff_addr = eff_addr;
        next_mem_req = mem_req;
        next_mem_addr = mem_addr;
        next_mem_istream = mem_istream;
        rfp.wr_en = 1'b0;
        rfp.wr_sel = cur_sel;
        rfp.wr_data = reg_stepped;
        // every completed stream fetch moves the counter past the word
        if (mem_req && mem_ack && mem_istream) begin
            rfp.wr_en = 1'b1;
            rfp.wr_sel = program_counter_reg;
            rfp.wr_data = pc_stepped;
        end
        case (state)
            OAG_IDLE: begin
                // requests while busy are simply not looked at
                if (start) begin
                    next_cur_mode = mode;
                    next_cur_sel = reg_sel;
                    next_cur_byte = byte_op;
                    next_busy = 1'b1;
                    next_in_reg = 1'b0;
                    next_is_imm = 1'b0;
                    next_ea_valid = 1'b0;
                    next_state = OAG_EVAL;
                end
            end
            OAG_EVAL: begin
                case (cur_mode)
                    MODE_REGISTER: begin
                        next_operand_value = rfp.rd_data;
                        next_in_reg = 1'b1;
                        next_done = 1'b1;
                        next_busy = 1'b0;
                        next_state = OAG_IDLE;
                    end
                    MODE_DEFERRED: begin
                        next_eff_addr = rfp.rd_data;
                        next_ea_valid = 1'b1;
                        next_done = 1'b1;
                        next_busy = 1'b0;
                        next_state = OAG_IDLE;
                    end
                    MODE_POST_INC, MODE_POST_INC_DEF: begin
                        if (sel_is_pc) begin
                            // immediate or absolute: the word after the instruction
                            next_mem_req = 1'b1;
                            next_mem_addr = rfp.pc_value;
                            next_mem_istream = 1'b1;
                            next_state = (cur_mode == MODE_POST_INC) ? OAG_IMM : OAG_PTR;
                        end else if (cur_mode == MODE_POST_INC) begin
                            next_eff_addr = rfp.rd_data;
                            next_ea_valid = 1'b1;
                            rfp.wr_en = 1'b1;
                            next_done = 1'b1;
                            next_busy = 1'b0;
                            next_state = OAG_IDLE;
                        end else begin
                            next_mem_req = 1'b1;
                            next_mem_addr = rfp.rd_data;
                            next_mem_istream = 1'b0;
                            rfp.wr_en = 1'b1;
                            next_state = OAG_PTR;
                        end
                    end
                    MODE_PRE_DEC: begin
                        rfp.wr_en = 1'b1;
                        next_eff_addr = reg_stepped;
                        next_ea_valid = 1'b1;
                        next_done = 1'b1;
                        next_busy = 1'b0;
                        next_state = OAG_IDLE;
                    end
                    MODE_PRE_DEC_DEF: begin
                        rfp.wr_en = 1'b1;
                        next_mem_req = 1'b1;
                        next_mem_addr = reg_stepped;
                        next_mem_istream = 1'b0;
                        next_state = OAG_PTR;
                    end
                    MODE_INDEX, MODE_INDEX_DEF: begin
                        next_mem_req = 1'b1;
                        next_mem_addr = rfp.pc_value;
                        next_mem_istream = 1'b1;
                        next_state = OAG_IDX;
                    end
                    default: begin
                        next_state = OAG_IDLE;
                    end
                endcase
            end
            OAG_IMM: begin
                if (mem_ack) begin
                    next_mem_req = 1'b0;
                    next_operand_value = mem_rdata;
                    next_is_imm = 1'b1;
                    next_done = 1'b1;
                    next_busy = 1'b0;
                    next_state = OAG_IDLE;
                end
            end
            OAG_IDX: begin
                if (mem_ack) begin
                    if (cur_mode == MODE_INDEX_DEF) begin
                        next_mem_addr = index_sum;
                        next_mem_istream = 1'b0;
                        next_state = OAG_PTR;
                    end else begin
                        next_mem_req = 1'b0;
                        next_eff_addr = index_sum;
                        next_ea_valid = 1'b1;
                        next_done = 1'b1;
                        next_busy = 1'b0;
                        next_state = OAG_IDLE;
                    end
                end
            end
            OAG_PTR: begin
                // the word read is the operand address
                if (mem_ack) begin
                    next_mem_req = 1'b0;
                    next_eff_addr = mem_rdata;
                    next_ea_valid = 1'b1;
                    next_done = 1'b1;
                    next_busy = 1'b0;
                    next_state = OAG_IDLE;
                end
            end
            default: begin
                next_state = OAG_IDLE;
                next_busy = 1'b0;
                next_mem_req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= OAG_IDLE;
            cur_mode <= MODE_REGISTER;
            cur_sel <= 3'h0;
            cur_byte <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            operand_in_reg <= 1'b0;
            operand_is_imm <= 1'b0;
            eff_addr_valid <= 1'b0;
            operand_value <= OAG_GPR_RESET;
            eff_addr <= OAG_GPR_RESET;
            mem_req <= 1'b0;
            mem_addr <= OAG_GPR_RESET;
            mem_istream <= 1'b0;
        end else begin
            state <= next_state;
            cur_mode <= next_cur_mode;
            cur_sel <= next_cur_sel;
            cur_byte <= next_cur_byte;
            busy <= next_busy;
            done <= next_done;
            operand_in_reg <= next_in_reg;
            operand_is_imm <= next_is_imm;
            eff_addr_valid <= next_ea_valid;
            operand_value <= next_operand_value;
            eff_addr <= next_eff_addr;
            mem_req <= next_mem_req;
            mem_addr <= next_mem_addr;
            mem_istream <= next_mem_istream;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    wire eval = (state == OAG_EVAL);

    mode_zero_a: assert property (eval && cur_mode == MODE_REGISTER |=> done && operand_in_reg && !mem_req
        && operand_value == $past(rfp.rd_data)) else $error("register mode result wrong");
    mode_one_a: assert property (eval && cur_mode == MODE_DEFERRED |-> !rfp.wr_en ##1
        eff_addr_valid && eff_addr == $past(rfp.rd_data)) else $error("deferred mode address wrong");
    post_inc_a: assert property (eval && cur_mode == MODE_POST_INC && cur_sel < stack_pointer_reg |->
        rfp.wr_en && rfp.wr_data == oag_word_t'(rfp.rd_data + (cur_byte ? OAG_STEP_BYTE : OAG_STEP_WORD)))
        else $error("post-increment step wrong");
    sp_step_a: assert property (eval && cur_mode == MODE_POST_INC && cur_sel == stack_pointer_reg |->
        rfp.wr_data == oag_word_t'(rfp.rd_data + OAG_STEP_WORD)) else $error("stack pointer step not two");
    ptr_inc_a: assert property (eval && cur_mode == MODE_POST_INC_DEF && !sel_is_pc |-> rfp.wr_en ##1
        mem_req && !mem_istream && mem_addr == $past(rfp.rd_data)) else $error("pointer read address wrong");
    pre_dec_a: assert property (eval && cur_mode == MODE_PRE_DEC && cur_sel < stack_pointer_reg |=>
        eff_addr == oag_word_t'($past(rfp.rd_data) - ($past(cur_byte) ? OAG_STEP_BYTE : OAG_STEP_WORD)))
        else $error("pre-decrement address wrong");
    ptr_dec_a: assert property (eval && cur_mode == MODE_PRE_DEC_DEF |=> mem_req
        && mem_addr == oag_word_t'($past(rfp.rd_data) - OAG_STEP_WORD)) else $error("pre-decrement pointer wrong");
    pc_fetch_a: assert property (mem_req && mem_ack && mem_istream |-> rfp.wr_en
        && rfp.wr_sel == program_counter_reg && rfp.wr_data == oag_word_t'(mem_addr + OAG_STEP_WORD))
        else $error("counter not advanced after stream fetch");
    imm_a: assert property (state == OAG_IMM && mem_ack |=> done && operand_is_imm
        && operand_value == $past(mem_rdata)) else $error("immediate operand wrong");
    pc_rel_a: assert property (state == OAG_IDX && mem_ack && sel_is_pc && cur_mode == MODE_INDEX |=>
        eff_addr == oag_word_t'($past(mem_rdata) + $past(mem_addr) + OAG_STEP_WORD)) else $error("relative sum wrong");
    index_a: assert property (state == OAG_IDX && mem_ack && !sel_is_pc && cur_mode == MODE_INDEX |=>
        eff_addr == oag_word_t'($past(mem_rdata) + $past(rfp.rd_data))) else $error("index sum wrong");
    req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped early");

    imm_c: cover property (state == OAG_IMM && mem_ack);
    rel_def_c: cover property (state == OAG_PTR && mem_ack && sel_is_pc && cur_mode == MODE_INDEX_DEF);
    dec_def_c: cover property (state == OAG_PTR && mem_ack && cur_mode == MODE_PRE_DEC_DEF);
    abs_c: cover property (state == OAG_PTR && mem_ack && mem_istream);

endmodule

// File: tb/oag_mem_model.sv
// oag_mem_model: behavioural memory read path facing the address generator
// assumes one clock; read data is a fixed function of the address
`timescale 1ns/1ps
module oag_mem_model
    import oag_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // request side
    input wire logic mem_req,
    input wire oag_word_t mem_addr,
    input wire logic mem_istream,
    input wire logic [3:0] wait_cycles,
    // answer side
    output logic mem_ack,
    output oag_word_t mem_rdata,
    // observation for the bench
    output logic last_istream,
    output logic [15:0] rd_count
);
    // ------------------------------------------------------------------
    // read answer
    // ------------------------------------------------------------------
    logic [3:0] cnt;

    // one ack per request; after an ack a cycle passes so a held request is not answered twice
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ack <= 1'b0;
            cnt <= 4'h0;
            mem_rdata <= 16'hFFFF;
            last_istream <= 1'b0;
            rd_count <= 16'h0000;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            cnt <= 4'h0;
            mem_rdata <= ~mem_rdata; // data no longer valid, so it moves
        end else if (mem_req && cnt >= wait_cycles) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem_addr ^ 16'h5A5A;
            last_istream <= mem_istream;
            rd_count <= rd_count + 16'h0001;
        end else begin
            cnt <= mem_req ? cnt + 4'h1 : 4'h0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// File: tb/oag_operand_address_generator_test.sv
// oag_operand_address_generator_test: self-checking bench for the generator
// assumes the memory model returns address xor 5A5A as read data
`timescale 1ns/1ps
module oag_operand_address_generator_test;
    import oag_pkg::*;
    logic sys_clk, reset_n, start, byte_op, load_en;
    logic [2:0] mode, reg_sel, load_sel;
    oag_word_t load_data, operand_value, eff_addr, mem_addr, mem_rdata;
    logic busy, done, operand_in_reg, operand_is_imm, eff_addr_valid, mem_req, mem_istream, mem_ack, last_istream;
    logic [3:0] wait_cycles;
    logic [15:0] rd_count;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;

    // ------------------------------------------------------------------
    // design and partner
    // ------------------------------------------------------------------
    oag_operand_address_generator i_oag_operand_address_generator (.sys_clk(sys_clk), .reset_n(reset_n),
        .start(start), .mode(mode), .reg_sel(reg_sel), .byte_op(byte_op), .busy(busy), .done(done),
        .operand_in_reg(operand_in_reg), .operand_is_imm(operand_is_imm), .operand_value(operand_value),
        .eff_addr_valid(eff_addr_valid), .eff_addr(eff_addr), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_istream(mem_istream), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .load_en(load_en),
        .load_sel(load_sel), .load_data(load_data));
    oag_mem_model i_oag_mem_model (.sys_clk(sys_clk), .reset_n(reset_n), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_istream(mem_istream), .wait_cycles(wait_cycles), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .last_istream(last_istream), .rd_count(rd_count));

    // clock of 8 ns; the cycle ceiling cuts a hang short
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    function automatic oag_word_t mem_word(input oag_word_t a);
        return a ^ 16'h5A5A;
    endfunction
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic load(input logic [2:0] s, input oag_word_t d);
        load_en = 1'b1;
        load_sel = s;
        load_data = d;
        @(posedge sys_clk) #1;
        load_en = 1'b0;
    endtask
    // issues one specifier and returns in the cycle where done is high
    task automatic run(input logic [2:0] m, input logic [2:0] s, input logic b);
        int k;
        start = 1'b1;
        mode = m;
        reg_sel = s;
        byte_op = b;
        @(posedge sys_clk) #1;
        chk("busy", 16'h0001, {15'h0000, busy});
        // start left high for one cycle while busy must be ignored
        @(posedge sys_clk) #1;
        start = 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++) @(posedge sys_clk) #1;
        chk("done", 16'h0001, {15'h0000, done});
        chk("idle", 16'h0000, {15'h0000, busy});
    endtask
    // reads a register back through mode 1 without touching it
    task automatic peek(input logic [2:0] s, input oag_word_t exp);
        run(MODE_DEFERRED, s, 1'b0);
        chk("reg value", exp, eff_addr);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_register_modes;
        logic [15:0] n;
        load(3'h0, 16'h1234);
        n = rd_count;
        run(MODE_REGISTER, 3'h0, 1'b0);
        chk("in_reg", 16'h0001, {15'h0000, operand_in_reg});
        chk("operand", 16'h1234, operand_value);
        chk("no read", n, rd_count);
        load(3'h1, 16'h2000);
        run(MODE_DEFERRED, 3'h1, 1'b0);
        chk("eff valid", 16'h0001, {15'h0000, eff_addr_valid});
        peek(3'h1, 16'h2000);
    endtask
    task automatic t_step_modes;
        load(3'h2, 16'h3000);
        run(MODE_POST_INC, 3'h2, 1'b1);
        chk("postinc addr", 16'h3000, eff_addr);
        peek(3'h2, 16'h3001);
        run(MODE_POST_INC, 3'h2, 1'b0);
        peek(3'h2, 16'h3003);
        load(3'h6, 16'h0800);
        run(MODE_POST_INC, 3'h6, 1'b1);
        peek(3'h6, 16'h0802);
        load(3'h4, 16'h0000);
        run(MODE_PRE_DEC, 3'h4, 1'b1);
        chk("predec addr", 16'hFFFF, eff_addr);
        run(MODE_PRE_DEC, 3'h4, 1'b0);
        chk("predec word", 16'hFFFD, eff_addr);
    endtask
    task automatic t_deferred_modes;
        wait_cycles = 4'h3;
        load(3'h3, 16'h4000);
        run(MODE_POST_INC_DEF, 3'h3, 1'b1);
        chk("ptr addr", mem_word(16'h4000), eff_addr);
        peek(3'h3, 16'h4002);
        load(3'h5, 16'h5000);
        run(MODE_PRE_DEC_DEF, 3'h5, 1'b1);
        chk("predec ptr", mem_word(16'h4FFE), eff_addr);
        peek(3'h5, 16'h4FFE);
        wait_cycles = 4'h0;
    endtask
    task automatic t_index_modes;
        load(3'h7, 16'h0100);
        run(MODE_INDEX, 3'h1, 1'b0);
        chk("stream", 16'h0001, {15'h0000, last_istream});
        chk("index addr", 16'h2000 + mem_word(16'h0100), eff_addr);
        run(MODE_INDEX_DEF, 3'h1, 1'b0);
        chk("idx def", mem_word(16'h2000 + mem_word(16'h0102)), eff_addr);
        chk("ptr data", 16'h0000, {15'h0000, last_istream});
        peek(3'h7, 16'h0104);
    endtask
    task automatic t_pc_modes;
        load(3'h7, 16'h0200);
        run(MODE_POST_INC, 3'h7, 1'b1);
        chk("imm flag", 16'h0001, {15'h0000, operand_is_imm});
        chk("imm value", mem_word(16'h0200), operand_value);
        run(MODE_POST_INC_DEF, 3'h7, 1'b0);
        chk("absolute", mem_word(16'h0202), eff_addr);
        run(MODE_INDEX, 3'h7, 1'b0);
        chk("relative", mem_word(16'h0204) + 16'h0206, eff_addr);
        wait_cycles = 4'h2;
        run(MODE_INDEX_DEF, 3'h7, 1'b0);
        chk("rel def", mem_word(mem_word(16'h0206) + 16'h0208), eff_addr);
        peek(3'h7, 16'h0208);
        wait_cycles = 4'h0;
    endtask
    // mid-run reset clears results and registers; a start right after release is taken
    task automatic t_reset;
        load(3'h6, 16'h0700);
        reset_n = 1'b0;
        @(posedge sys_clk) #1;
        chk("rst valid", 16'h0000, {15'h0000, eff_addr_valid});
        chk("rst addr", 16'h0000, eff_addr);
        reset_n = 1'b1;
        peek(3'h6, 16'h0000);
        peek(3'h7, 16'h0000);
    endtask

    // ------------------------------------------------------------------
    // verdict
    // ------------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // reset for four cycles, then the scenarios in turn
    initial begin
        reset_n = 1'b0;
        start = 1'b0;
        mode = 3'h0;
        reg_sel = 3'h0;
        byte_op = 1'b0;
        load_en = 1'b0;
        load_sel = 3'h0;
        load_data = 16'h0000;
        wait_cycles = 4'h0;
        repeat (4) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        t_register_modes();
        t_step_modes();
        t_deferred_modes();
        t_index_modes();
        t_pc_modes();
        t_reset();
        end_sim();
    end
endmodule
